// ==== rfo_pkg.sv ====
`default_nettype none
package rfo_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_FORCE = 12'hA03;
  localparam logic [11:0] IDX_BYPASS = 12'hA04;
  localparam logic [11:0] IDX_GRP_CLR = 12'hA05;
  localparam logic [11:0] IDX_SYS_CLR = 12'hA06;
  localparam logic [11:0] IDX_PAIR0_CLR = 12'hA07;
  localparam logic [11:0] IDX_PAIR1_CLR = 12'hA08;
  localparam logic [11:0] IDX_SYS_MON = 12'hD08;
  localparam logic [11:0] IDX_PAIR0_MON = 12'hD09;
  localparam logic [11:0] IDX_PAIR1_MON = 12'hD0A;
  localparam logic [11:0] IDX_FAULT_STAT = 12'hD0B;

  // Reset values of the writable controls
  localparam logic [3:0] FORCE_RST = 4'h0;
  localparam logic [3:0] BYPASS_RST = 4'h0;

  // Latched monitor vector layout
  localparam int MON_W = 25;
  localparam int SYS_LSB = 0;
  localparam int PAIR0_LSB = 8;
  localparam int PAIR1_LSB = 16;
  localparam int WDOG_ALERT_BIT = 24;
  localparam int SYS_EVT_POS = 2;
  localparam int EVT_FAULT = 0;
  localparam int EVT_CLEARED = 1;
  localparam int EVT_VALID = 2;
  localparam int EVT_STRIDE = 4;

  // Implemented bits of each clear byte
  localparam logic [7:0] SYS_MASK = 8'hFC;
  localparam logic [7:0] PAIR_MASK = 8'h77;
  localparam logic [24:0] COMMON_MASK = 25'h0777_7FC;
  localparam logic [24:0] ALL_MASK = 25'h1777_7FC;

  // Group clear bit positions
  localparam int GRP_ALL = 0;
  localparam int GRP_COMMON = 1;
  localparam int GRP_LOOP0 = 2;
  localparam int GRP_WDOG = 7;
endpackage
`default_nettype wire

// ==== rfo_mon_if.sv ====
`default_nettype none
interface rfo_mon_if #(parameter int W = 25);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flag;
  // Latch owns the flags, controller raises events and clears
  modport latch (input set, input clr, output flag);
  modport ctrl (output set, output clr, input flag);
endinterface
`default_nettype wire

// ==== rfo_sync.sv ====
`default_nettype none
module rfo_sync #(parameter int W = 4) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, filtered level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted once two late stages agree, filtering one-cycle glitches
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        q[i] <= 1'b0;
      else if (s2_q[i] == s3_q[i])
        q[i] <= s3_q[i];
    end
  end
endmodule
`default_nettype wire

// ==== rfo_mon_latch.sv ====
`default_nettype none
module rfo_mon_latch #(parameter int W = 25) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event and clear carrier
  rfo_mon_if.latch bus
);
  // Sticky flags; an event in the clearing cycle survives
  for (genvar i = 0; i < W; i++)
  begin : g_flag
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        bus.flag[i] <= 1'b0;
      else
        bus.flag[i] <= bus.set[i] | (bus.flag[i] & ~bus.clr[i]); // RULE13
    end

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n) bus.set[i] |=> bus.flag[i]) // RULE13
      else $error("event lost in monitor flag");
    a_clr_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      (bus.clr[i] && !bus.set[i]) |=> !bus.flag[i])
      else $error("clear did not reset monitor flag");
  end
endmodule
`default_nettype wire

// ==== rfo_top.sv ====
// Design decision made here: the APB register port.
`default_nettype none
// Behaviour
// (RULE1) Force-fault bit per input, reset 0; set means input faulted, unused.
// (RULE2) Bypass bit makes input unfaulted despite monitor; force-fault still wins.
// (RULE3) Bypass bits reset to 0 so monitors decide fault state.
// (RULE4) Writing 1 to a clear bit resets its latched monitor bit.
// (RULE5) Clear bits return to 0 by themselves after clearing.
// (RULE6) Clear bits sit at the same positions as monitor bits.
// (RULE7) Group: bit0 all, bit1 common, bits2-5 loops 0-3, bit6 reserved.
// (RULE8) Group bit 7 clears the watchdog alert.
// (RULE9) System PLL clear bits 7,5,4,3,2 as listed; bits 1:0 reserved.
// (RULE10) System PLL clear bit 6 clears the stability-expired event.
// (RULE11) First pair clear: bits 0-2 input 0, bits 4-6 input 1.
// (RULE12) Second pair clear: bits 0-2 input 2, bits 4-6 input 3.
// (RULE13) Writing 0 does nothing; a recurring event sets its bit again.
module rfo_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frequency monitor fault levels from the input receivers
  input wire logic [3:0] ref_monitor_fault,
  // Event pulses on pclk: [5] unlocked [4] stable [3] locked [2] cal end [1] cal start [0] watchdog
  input wire logic [5:0] sys_pll_evt,
  input wire logic [3:0] ref_validated_evt,
  // Fault state, latched monitors and loop clear pulses
  output logic [3:0] ref_faulted,
  output logic [24:0] irq_monitor,
  output logic [3:0] loop_irq_clear
);
  logic [3:0] force_q;
  logic [3:0] bypass_q;
  logic [3:0] faulted_q;
  logic [3:0] faulted_d;
  logic [3:0] mon_fault_s;
  logic [24:0] set_d;
  logic [24:0] clr_d;
  logic [24:0] clr_q;
  logic [3:0] loop_clr_d;
  logic [3:0] loop_clr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic hit;
  logic [7:0] rd_byte;
  logic setup;
  logic wr;
  logic init_q;

  rfo_mon_if #(.W(rfo_pkg::MON_W)) mon_if ();

  // Monitor fault pins come from the receivers' own timing
  rfo_sync #(.W(4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(ref_monitor_fault),
    .q(mon_fault_s)
  );

  rfo_mon_latch #(.W(rfo_pkg::MON_W)) u_latch (
    .clk(pclk),
    .rst_n(presetn),
    .bus(mon_if.latch)
  );

  // Byte address of a register index
  function automatic logic [15:0] baddr(input logic [11:0] idx);
    baddr = {2'b00, idx, 2'b00};
  endfunction

  // Bus phases; a write lands only on the accepted access edge
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_q & pwrite & pstrb[0] & ~pslverr_q;

  // Read decode; clear registers are write-only and read as zero
  always_comb
  begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      baddr(rfo_pkg::IDX_FORCE): rd_byte = {4'h0, force_q};
      baddr(rfo_pkg::IDX_BYPASS): rd_byte = {4'h0, bypass_q};
      baddr(rfo_pkg::IDX_GRP_CLR): rd_byte = 8'h00;
      baddr(rfo_pkg::IDX_SYS_CLR): rd_byte = 8'h00;
      baddr(rfo_pkg::IDX_PAIR0_CLR): rd_byte = 8'h00;
      baddr(rfo_pkg::IDX_PAIR1_CLR): rd_byte = 8'h00;
      baddr(rfo_pkg::IDX_SYS_MON): rd_byte = mon_if.flag[7:0];
      baddr(rfo_pkg::IDX_PAIR0_MON): rd_byte = mon_if.flag[15:8];
      baddr(rfo_pkg::IDX_PAIR1_MON): rd_byte = mon_if.flag[23:16];
      baddr(rfo_pkg::IDX_FAULT_STAT): rd_byte = {3'b000, mon_if.flag[rfo_pkg::WDOG_ALERT_BIT], faulted_q};
      default: hit = 1'b0;
    endcase
  end

  // No wait state: setup cycle captures the answer, access cycle shows it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup)
        prdata_q <= (!pwrite && hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Control registers; reset leaves every input under its own monitor
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      force_q <= rfo_pkg::FORCE_RST; // RULE1
      bypass_q <= rfo_pkg::BYPASS_RST; // RULE3
    end
    else if (wr)
    begin
      if (paddr == baddr(rfo_pkg::IDX_FORCE))
        force_q <= pwdata[3:0]; // RULE1
      if (paddr == baddr(rfo_pkg::IDX_BYPASS))
        bypass_q <= pwdata[3:0]; // RULE2
    end
  end

  // Force beats bypass, bypass beats the frequency monitor
  assign faulted_d = force_q | (mon_fault_s & ~bypass_q); // RULE1 RULE2

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      faulted_q <= 4'h0;
    else
      faulted_q <= faulted_d;
  end

  // Event vector: system PLL events plus fault edges and validation per input
  always_comb
  begin
    set_d = '0;
    set_d[rfo_pkg::SYS_EVT_POS +: 6] = sys_pll_evt;
    set_d[rfo_pkg::WDOG_ALERT_BIT] = sys_pll_evt[0];
    for (int i = 0; i < 4; i++)
    begin
      set_d[rfo_pkg::PAIR0_LSB + i * rfo_pkg::EVT_STRIDE + rfo_pkg::EVT_FAULT] = faulted_d[i] & ~faulted_q[i];
      set_d[rfo_pkg::PAIR0_LSB + i * rfo_pkg::EVT_STRIDE + rfo_pkg::EVT_CLEARED] = ~faulted_d[i] & faulted_q[i];
      set_d[rfo_pkg::PAIR0_LSB + i * rfo_pkg::EVT_STRIDE + rfo_pkg::EVT_VALID] = ref_validated_evt[i];
    end
  end

  // Clear decode; zeros written clear nothing, reserved bits are masked off
  always_comb
  begin
    clr_d = '0;
    loop_clr_d = 4'h0;
    if (wr)
    begin
      case (paddr)
        baddr(rfo_pkg::IDX_GRP_CLR):
        begin
          if (pwdata[rfo_pkg::GRP_ALL])
          begin
            clr_d = rfo_pkg::ALL_MASK; // RULE7
            loop_clr_d = 4'hF; // RULE7
          end
          else
          begin
            if (pwdata[rfo_pkg::GRP_COMMON])
              clr_d = rfo_pkg::COMMON_MASK; // RULE7
            loop_clr_d = pwdata[rfo_pkg::GRP_LOOP0 +: 4]; // RULE7
          end
          if (pwdata[rfo_pkg::GRP_WDOG])
            clr_d[rfo_pkg::WDOG_ALERT_BIT] = 1'b1; // RULE8
        end
        baddr(rfo_pkg::IDX_SYS_CLR):
          clr_d[rfo_pkg::SYS_LSB +: 8] = pwdata[7:0] & rfo_pkg::SYS_MASK; // RULE6 RULE9 RULE10
        baddr(rfo_pkg::IDX_PAIR0_CLR):
          clr_d[rfo_pkg::PAIR0_LSB +: 8] = pwdata[7:0] & rfo_pkg::PAIR_MASK; // RULE6 RULE11
        baddr(rfo_pkg::IDX_PAIR1_CLR):
          clr_d[rfo_pkg::PAIR1_LSB +: 8] = pwdata[7:0] & rfo_pkg::PAIR_MASK; // RULE6 RULE12
        default: clr_d = '0;
      endcase
    end
  end

  // Clear strobes live one cycle, so software never writes them back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_q <= '0;
      loop_clr_q <= 4'h0;
    end
    else
    begin
      clr_q <= clr_d; // RULE5
      loop_clr_q <= loop_clr_d; // RULE5
    end
  end

  assign mon_if.set = set_d;
  assign mon_if.clr = clr_q; // RULE4

  // Marks the first cycle after reset release, for checking only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      init_q <= 1'b0;
    else
      init_q <= 1'b1;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ref_faulted = faulted_q;
  assign irq_monitor = mon_if.flag;
  assign loop_irq_clear = loop_clr_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_force_faults: assert property (force_q != 4'h0 |=> (faulted_q & $past(force_q)) == $past(force_q)) // RULE1
    else $error("forced input not faulted");
  a_bypass_unfaults: assert property (##1 faulted_q == $past(force_q | (mon_fault_s & ~bypass_q))) // RULE2
    else $error("fault state ignores bypass or force");
  a_bypass_reset: assert property (!init_q |-> bypass_q == 4'h0 && force_q == 4'h0) // RULE3
    else $error("bypass not zero after reset");
  a_clear_sys_lock: assert property ((wr && paddr == baddr(rfo_pkg::IDX_SYS_CLR) && pwdata[7]) // RULE4 RULE9
    ##1 !sys_pll_evt[5] |=> !irq_monitor[7])
    else $error("unlock event not cleared");
  a_clear_self: assert property (clr_q != '0 |=> clr_q == '0 && loop_clr_q == 4'h0) // RULE5
    else $error("clear strobe did not self clear");
  a_clear_layout: assert property ((clr_q & ~rfo_pkg::ALL_MASK) == '0) // RULE6
    else $error("reserved clear bit active");
  a_group_all: assert property ((wr && paddr == baddr(rfo_pkg::IDX_GRP_CLR) && pwdata[0]) // RULE7
    |=> clr_q == rfo_pkg::ALL_MASK && loop_clr_q == 4'hF)
    else $error("clear all incomplete");
  a_group_wdog: assert property ((wr && paddr == baddr(rfo_pkg::IDX_GRP_CLR) && pwdata[7]) // RULE8
    |=> clr_q[rfo_pkg::WDOG_ALERT_BIT])
    else $error("watchdog alert clear missing");
  a_sys_stable: assert property ((wr && paddr == baddr(rfo_pkg::IDX_SYS_CLR) && pwdata[6]) |=> clr_q[6]) // RULE10
    else $error("stable event clear missing");
  a_pair0_map: assert property ((wr && paddr == baddr(rfo_pkg::IDX_PAIR0_CLR)) // RULE11
    |=> clr_q[15:8] == ($past(pwdata[7:0]) & rfo_pkg::PAIR_MASK))
    else $error("pair 0 clear misplaced");
  a_pair1_map: assert property ((wr && paddr == baddr(rfo_pkg::IDX_PAIR1_CLR)) // RULE12
    |=> clr_q[23:16] == ($past(pwdata[7:0]) & rfo_pkg::PAIR_MASK))
    else $error("pair 1 clear misplaced");
  a_zero_write: assert property ((wr && pwdata[7:0] == 8'h00) |=> clr_q == '0 && loop_clr_q == 4'h0) // RULE13
    else $error("zero write cleared something");

  // Bus answer comes one cycle after setup and stands for that cycle only
  a_ready_after_setup: assert property ((psel && !penable) |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_error_unmapped: assert property ((psel && !penable && !hit) |=> pready && pslverr)
    else $error("unmapped access without error");
  // Write-only clears read as zero; status shows the fault state of the setup cycle
  a_clear_read_zero: assert property ((psel && !penable && !pwrite && paddr == baddr(rfo_pkg::IDX_GRP_CLR)) // RULE5
    |=> prdata == 32'h0000_0000)
    else $error("clear register read not zero");
  a_status_read: assert property ((psel && !penable && !pwrite && paddr == baddr(rfo_pkg::IDX_FAULT_STAT)) // RULE1
    |=> prdata[3:0] == $past(faulted_q))
    else $error("status read lost fault state");
  // Bypass hides a monitor fault only where no force bit is set
  a_bypass_hides: assert property ((bypass_q & ~force_q) != 4'h0 // RULE2
    |=> (faulted_q & $past(bypass_q & ~force_q)) == 4'h0)
    else $error("bypassed input still faulted");
  a_force_wins: assert property ((force_q & bypass_q) != 4'h0 // RULE2
    |=> (faulted_q & $past(force_q & bypass_q)) == $past(force_q & bypass_q))
    else $error("bypass overrode force");
  // Loop pulses follow the written group bits; they cannot stick
  a_group_loops: assert property ((wr && paddr == baddr(rfo_pkg::IDX_GRP_CLR) && !pwdata[0]) // RULE7
    |=> loop_clr_q == $past(pwdata[5:2]))
    else $error("loop group clear misplaced");
  a_group_common: assert property ((wr && paddr == baddr(rfo_pkg::IDX_GRP_CLR) && pwdata[1]) // RULE7
    |=> (clr_q & rfo_pkg::COMMON_MASK) == rfo_pkg::COMMON_MASK)
    else $error("common group clear incomplete");
  a_sys_map: assert property ((wr && paddr == baddr(rfo_pkg::IDX_SYS_CLR)) // RULE9
    |=> clr_q[7:0] == ($past(pwdata[7:0]) & rfo_pkg::SYS_MASK))
    else $error("system PLL clear misplaced");
  a_loop_self_clear: assert property (loop_clr_q != 4'h0 |=> loop_clr_q == 4'h0) // RULE5
    else $error("loop clear pulse stuck");

  c_force_write: cover property (wr && paddr == baddr(rfo_pkg::IDX_FORCE) && pwdata[3:0] != 4'h0);
  c_group_clear: cover property (wr && paddr == baddr(rfo_pkg::IDX_GRP_CLR) && pwdata[0]);
  c_set_and_clear: cover property ((clr_q & set_d) != '0);
  c_bus_error: cover property (pready_q && pslverr_q);
  c_bypass_hides: cover property ((bypass_q & ~force_q & mon_fault_s) != 4'h0);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk;
  logic presetn;
  logic [15:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] ref_monitor_fault;
  logic [5:0] sys_pll_evt;
  logic [3:0] ref_validated_evt;
  logic [3:0] ref_faulted;
  logic [24:0] irq_monitor;
  logic [3:0] loop_irq_clear;
  int n_fail;
  int n_compared;
  logic [31:0] rd;
  logic err;
  // Clear table: register, written byte, monitor bits expected to drop
  logic [11:0] t_idx [9];
  logic [7:0] t_dat [9];
  logic [24:0] t_clr [9];
  logic [24:0] exp_mon;

  rfo_top dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_monitor_fault(ref_monitor_fault), .sys_pll_evt(sys_pll_evt),
    .ref_validated_evt(ref_validated_evt), .ref_faulted(ref_faulted),
    .irq_monitor(irq_monitor), .loop_irq_clear(loop_irq_clear)
  );

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, then let the clear strobe act before the monitor is looked at
  task automatic wr_settle(input logic [11:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d, rd, err);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Event pulses last one cycle; monitor sets at the following edge
  task automatic pulse(input logic [5:0] s, input logic [3:0] v);
    @(posedge pclk);
    sys_pll_evt <= s;
    ref_validated_evt <= v;
    @(posedge pclk);
    sys_pll_evt <= 6'h00;
    ref_validated_evt <= 4'h0;
    @(posedge pclk);
    #1;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial
  begin
    presetn = 1'b0;
    paddr = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    ref_monitor_fault = 4'h0;
    sys_pll_evt = 6'h00;
    ref_validated_evt = 4'h0;
    n_fail = 0;
    n_compared = 0;
    t_idx = '{rfo_pkg::IDX_SYS_CLR, rfo_pkg::IDX_SYS_CLR, rfo_pkg::IDX_SYS_CLR, rfo_pkg::IDX_PAIR0_CLR,
              rfo_pkg::IDX_PAIR0_CLR, rfo_pkg::IDX_PAIR1_CLR, rfo_pkg::IDX_GRP_CLR, rfo_pkg::IDX_GRP_CLR,
              rfo_pkg::IDX_GRP_CLR};
    t_dat = '{8'h03, 8'h40, 8'h84, 8'h88, 8'h04, 8'h40, 8'h80, 8'h40, 8'h02};
    t_clr = '{25'h0000000, 25'h0000040, 25'h0000084, 25'h0000000, 25'h0000400, 25'h0400000,
              25'h1000000, 25'h0000000, 25'h0FFFFFC};
    do_reset();
    // Reset state and an unmapped access
    #1;
    chk(32'(ref_faulted), 32'h0);
    chk(32'(irq_monitor), 32'h0);
    apb(rfo_pkg::IDX_FORCE, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h0);
    apb(rfo_pkg::IDX_BYPASS, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h0);
    apb(12'h000, 1'b0, 8'h00, rd, err);
    chk(32'(err), 32'h1);
    // Every system PLL and validation event once, then per-bit and group clears in turn
    pulse(6'h3F, 4'hF);
    exp_mon = 25'h14444FC;
    chk(32'(irq_monitor), 32'(exp_mon));
    for (int i = 0; i < 9; i++)
    begin
      wr_settle(t_idx[i], t_dat[i]);
      exp_mon = exp_mon & ~t_clr[i];
      chk(32'(irq_monitor), 32'(exp_mon));
    end
    // A recurring event latches again after its clear
    pulse(6'h10, 4'h0);
    chk(32'(irq_monitor), 32'h40);
    // Clear strobe and a recurring event in the same cycle: the event survives
    apb(rfo_pkg::IDX_SYS_CLR, 1'b1, 8'h40, rd, err);
    sys_pll_evt <= 6'h10;
    @(posedge pclk);
    sys_pll_evt <= 6'h00;
    @(posedge pclk);
    #1;
    chk(32'(irq_monitor), 32'h40);
    // Loop group clears pulse once and fall back by themselves
    for (int i = 0; i < 4; i++)
    begin
      apb(rfo_pkg::IDX_GRP_CLR, 1'b1, 8'(8'h04 << i), rd, err);
      #1;
      chk(32'(loop_irq_clear), 32'(1 << i));
      @(posedge pclk);
      #1;
      chk(32'(loop_irq_clear), 32'h0);
    end
    chk(32'(irq_monitor), 32'h40);
    pulse(6'h3F, 4'hF);
    apb(rfo_pkg::IDX_GRP_CLR, 1'b1, 8'h01, rd, err);
    #1;
    chk(32'(loop_irq_clear), 32'hF);
    @(posedge pclk);
    @(posedge pclk);
    #1;
    chk(32'(irq_monitor), 32'h0);
    apb(rfo_pkg::IDX_GRP_CLR, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h0);
    // Monitor faults, bypass, then force which wins over bypass
    ref_monitor_fault <= 4'hA;
    repeat (8) @(posedge pclk);
    #1;
    chk(32'(ref_faulted), 32'hA);
    wr_settle(rfo_pkg::IDX_BYPASS, 8'h03);
    chk(32'(ref_faulted), 32'h8);
    wr_settle(rfo_pkg::IDX_FORCE, 8'h05);
    chk(32'(ref_faulted), 32'hD);
    chk(32'(irq_monitor), 32'h113100);
    apb(rfo_pkg::IDX_FORCE, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h5);
    apb(rfo_pkg::IDX_BYPASS, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h3);
    // Zero write clears nothing; monitor and status read back in place
    wr_settle(rfo_pkg::IDX_PAIR0_CLR, 8'h00);
    chk(32'(irq_monitor), 32'h113100);
    apb(rfo_pkg::IDX_PAIR0_MON, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h31);
    apb(rfo_pkg::IDX_PAIR1_MON, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h11);
    apb(rfo_pkg::IDX_FAULT_STAT, 1'b0, 8'h00, rd, err);
    chk(rd, 32'hD);
    // A second reset in mid-run restores the controls
    ref_monitor_fault <= 4'h0;
    do_reset();
    #1;
    chk(32'(ref_faulted), 32'h0);
    chk(32'(irq_monitor), 32'h0);
    apb(rfo_pkg::IDX_FORCE, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h0);
    apb(rfo_pkg::IDX_BYPASS, 1'b0, 8'h00, rd, err);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
